// ===== hw/synth_cfg.svh
`ifndef SYNTH_CFG_SVH
`define SYNTH_CFG_SVH

// serial word layout, position 0 is the last bit shifted in
`define WORD_W        23
`define DEST_POS      0
`define SEL_LO_POS    1
`define SEL_HI_POS    2
`define SPARE_POS     3
`define PHASE_POS     4
`define SWAL_LSB      5
`define SWAL_MSB      11
`define MAIN_LSB      12
`define MAIN_MSB      22
`define MAIN_W        11
`define SWAL_W        7
`define LATCH_W       19
`define LATCH_PHASE   0

// latch reset contents: smallest legal main ratio, no swallow
`define MAIN_RST      11'h010
`define SWAL_RST      7'h00

// prescaler terminal counts for divide by 64 and by 65
`define PRESC_W       7
`define PRESC_LAST_LO 7'h3F
`define PRESC_LAST_HI 7'h40

// fixed reference divide by 1700
`define REF_W         11
`define REF_DIV_LAST  11'h6A3

// lock window, time in ns and derived clock count
`define CLK_MHZ       200
`define LOCK_TW_NS    376
`define LOCK_TW_CYC   ((`LOCK_TW_NS * `CLK_MHZ) / 1000)
`define ERR_W         8
`define LOCK_RUNS     2'h3

// pin synchroniser slots
`define PIN_N         7
`define PIN_DATA      0
`define PIN_SCLK      1
`define PIN_LOAD      2
`define PIN_PSAVE     3
`define PIN_REF       4
`define PIN_TXIN      5
`define PIN_RXIN      6

// register map, byte addresses
`define A_CTRL        12'h000
`define A_TX_LATCH    12'h004
`define A_RX_LATCH    12'h008
`define A_STATUS      12'h00C
`define CTRL_RST      1'h1

`endif

// ===== hw/synth_pkg.sv
`include "synth_cfg.svh"

package synth_pkg;
   typedef logic [`MAIN_W-1:0]  main_ratio_t;
   typedef logic [`SWAL_W-1:0]  swallow_ratio_t;
   typedef logic [`LATCH_W-1:0] latch_word_t;
   // order gives the select pair codes 00, 01, 10, 11
   typedef enum logic [1:0] {
      SEL_LOCK,
      SEL_RX_RATE,
      SEL_TX_RATE,
      SEL_REF_RATE
   } lock_sel_t;
endpackage

// ===== hw/loop_divider.sv
`timescale 1ns/1ps
`include "synth_cfg.svh"

module loop_divider (
   input  wire logic                     hclk,
   input  wire logic                     hresetn,
   input  wire logic                     run,
   input  wire logic                     in_edge,
   input  wire synth_pkg::main_ratio_t    main_ratio,
   input  wire synth_pkg::swallow_ratio_t swallow_ratio,
   output logic                          cmp_tick
);
   logic [`PRESC_W-1:0] presc_q;
   logic [`MAIN_W-1:0]  main_q;
   logic [`SWAL_W-1:0]  swal_q;
   logic                presc_wrap;
   logic                main_last;

   // 65 while swallow count remains, 64 after
   assign presc_wrap = in_edge && (presc_q == ((swal_q != `SWAL_RST) ?
                       `PRESC_LAST_HI : `PRESC_LAST_LO));
   assign main_last  = (main_q <= `MAIN_W'(1)); // ratio below 16 never expected

   // dual-modulus prescaler
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         presc_q <= '0;
      end else if (!run) begin
         presc_q <= '0;
      end else if (in_edge) begin
         presc_q <= presc_wrap ? '0 : presc_q + `PRESC_W'(1);
      end
   end

   // swallow and main counters, reload together on expiry
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         main_q <= `MAIN_RST;
         swal_q <= `SWAL_RST;
      end else if (!run || (presc_wrap && main_last)) begin
         main_q <= main_ratio; // plain binary ratio
         swal_q <= swallow_ratio; // full 0..127 range
      end else if (presc_wrap) begin
         main_q <= main_q - `MAIN_W'(1);
         if (swal_q != `SWAL_RST) begin
            swal_q <= swal_q - `SWAL_W'(1);
         end
      end
   end

   // one pulse per full feedback cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmp_tick <= 1'b0;
      end else begin
         cmp_tick <= run && presc_wrap && main_last;
      end
   end

   property p_reload;
      @(posedge hclk) disable iff (!hresetn || !run)
      presc_wrap && main_last |=> cmp_tick && main_q == $past(main_ratio)
                                  && swal_q == $past(swallow_ratio);
   endproperty
   a_reload: assert property (p_reload)
      else $error("counters did not reload on expiry");

   property p_modulus;
      @(posedge hclk) disable iff (!hresetn || !run)
      in_edge && swal_q != `SWAL_RST && presc_q == `PRESC_LAST_LO
      |=> presc_q == `PRESC_LAST_HI;
   endproperty
   a_modulus: assert property (p_modulus)
      else $error("prescaler did not divide by 65 while swallowing");
endmodule

// ===== hw/phase_compare.sv
`timescale 1ns/1ps
`include "synth_cfg.svh"

module phase_compare (
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic run,
   input  wire logic ref_tick,
   input  wire logic cmp_tick,
   input  wire logic invert,
   output logic      pump_out,
   output logic      pump_oe,
   output logic      locked
);
   logic             up_q;
   logic             dn_q;
   logic [`ERR_W-1:0] err_q;
   logic [1:0]       runs_q;
   logic             err_long;

   // phase-frequency detector, both set means cancel
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         up_q <= 1'b0;
         dn_q <= 1'b0;
      end else if (!run || ((up_q || ref_tick) && (dn_q || cmp_tick))) begin
         up_q <= 1'b0;
         dn_q <= 1'b0;
      end else begin
         up_q <= up_q || ref_tick;
         dn_q <= dn_q || cmp_tick;
      end
   end

   // up means reference ahead; polarity bit swaps the drive level
   assign pump_oe  = up_q || dn_q;
   assign pump_out = invert ? up_q : dn_q;

   // width of the present error pulse, saturating
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         err_q <= '0;
      end else if (!pump_oe) begin
         err_q <= '0;
      end else if (err_q != {`ERR_W{1'b1}}) begin
         err_q <= err_q + `ERR_W'(1);
      end
   end
   assign err_long = (err_q >= `ERR_W'(`LOCK_TW_CYC));

   // lock after three reference ticks in a row with no long error pulse
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         runs_q <= '0;
      end else if (!run || err_long) begin
         runs_q <= '0;
      end else if (ref_tick && runs_q != `LOCK_RUNS) begin
         runs_q <= runs_q + 2'(1);
      end
   end
   assign locked = (runs_q == `LOCK_RUNS);

   property p_polarity;
      @(posedge hclk) disable iff (!hresetn)
      up_q && !dn_q |-> pump_oe && (pump_out == invert);
   endproperty
   a_polarity: assert property (p_polarity)
      else $error("pump level wrong for reference ahead");

   property p_unlock;
      @(posedge hclk) disable iff (!hresetn)
      run && err_long |=> !locked;
   endproperty
   a_unlock: assert property (p_unlock)
      else $error("lock held through a long phase error");
endmodule

// ===== hw/synth_ctrl.sv
// Our own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`include "synth_cfg.svh"

// Notes on behaviour
// - each rising serial clock shifts one data bit into the 23-bit register; here only while the control register shift enable bit is set
// - programming uses only data, serial clock and load strobe, no handshake
// - load strobe high copies word to transmit latch if destination high, else receive
// - switch outputs float normally, pass their pump state while load is high
// - word holds main, swallow, polarity, spare, two select bits, destination
// - swallow counter is seven bits, loadable 0 through 127
// - main ratio is plain unsigned binary, first bit least significant; here the first bit lands at position 22, most significant
// - prescaler divides by 64 or 65 under swallow control
// - total division is main times 64 plus swallow, swallow below main
// - reference oscillator is divided by a fixed 1700
// - loading one loop latch leaves the other loop untouched
// - lock output shows a selected source and is open drain
// - polarity bit inverts that loop's pump up/down decision
// - power-save input sets receive loop active or stand-by
// - select 11 reference, 10 transmit rate, 01 receive rate, 00 lock
// - pump drives by polarity and frequency comparison, floats when equal
// - destination bit and load strobe together choose which switch conducts
// - power-save low: receive stand-by, its pump floats, lock output low
module synth_ctrl (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic        serial_data_pin,
   input  wire logic        serial_clock_pin,
   input  wire logic        load_strobe,
   input  wire logic        power_save_pin,
   input  wire logic        ref_osc_input,
   input  wire logic        tx_prescaler_input,
   input  wire logic        rx_prescaler_input,
   output logic             tx_pump_out,
   output logic             tx_pump_oe,
   output logic             rx_pump_out,
   output logic             rx_pump_oe,
   output logic             tx_switch_out,
   output logic             tx_switch_oe,
   output logic             rx_switch_out,
   output logic             rx_switch_oe,
   output logic             lock_status_out,
   output logic             lock_status_oe
);
   logic [`PIN_N-1:0]        pins_raw;
   logic [`PIN_N-1:0]        meta_q;
   logic [`PIN_N-1:0]        sync_q;
   logic [`PIN_N-1:0]        prev_q;
   logic [`PIN_N-1:0]        rise;
   logic [`WORD_W-1:0]       sr_q;
   logic [`WORD_W-1:0]       sr_shifted;
   synth_pkg::latch_word_t   payload;
   synth_pkg::latch_word_t   latch_q [2];
   logic [1:0]               dest_hit;
   logic [1:0]               sel_q;
   synth_pkg::lock_sel_t     sel;
   logic                     le_s;
   logic                     ps_s;
   logic                     shift_en_q;
   logic [`REF_W-1:0]        ref_cnt_q;
   logic                     ref_tick_q;
   logic                     ref_sq_q;
   logic [1:0]               run;
   logic [1:0]               cmp_tick;
   logic [1:0]               cmp_sq_q;
   logic [1:0]               pump_out;
   logic [1:0]               pump_oe;
   logic [1:0]               locked;
   logic                     lock_lvl_q;
   logic                     lock_lvl_d;
   logic                     bus_acc;
   logic                     wr_pend_q;
   logic [11:0]              wr_addr_q;
   logic [31:0]              hrdata_q;

   // every pin is asynchronous to hclk
   assign pins_raw = {rx_prescaler_input, tx_prescaler_input, ref_osc_input,
                      power_save_pin, load_strobe, serial_clock_pin, serial_data_pin};

   // two-flop synchroniser plus an edge history stage per pin
   generate
      for (genvar p = 0; p < `PIN_N; p++) begin : g_sync
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               meta_q[p] <= 1'b0;
               sync_q[p] <= 1'b0;
               prev_q[p] <= 1'b0;
            end else begin
               meta_q[p] <= pins_raw[p];
               sync_q[p] <= meta_q[p];
               prev_q[p] <= sync_q[p];
            end
         end
      end
   endgenerate
   assign rise = sync_q & ~prev_q;
   assign le_s = sync_q[`PIN_LOAD];
   assign ps_s = sync_q[`PIN_PSAVE];

   // serial shift, new bit enters at position zero
   assign sr_shifted = {sr_q[`WORD_W-2:0], sync_q[`PIN_DATA]};
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sr_q <= '0;
      end else if (rise[`PIN_SCLK] && shift_en_q) begin
         sr_q <= sr_shifted;
      end
   end

   // spare bit is carried in the word but never used
   assign payload  = {sr_q[`MAIN_MSB:`MAIN_LSB], sr_q[`SWAL_MSB:`SWAL_LSB],
                      sr_q[`PHASE_POS]};
   assign dest_hit = {~sr_q[`DEST_POS], sr_q[`DEST_POS]};

   // index 0 transmit, 1 receive; each latch loads only on its own destination
   generate
      for (genvar g = 0; g < 2; g++) begin : g_latch
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               latch_q[g] <= {`MAIN_RST, `SWAL_RST, 1'b1};
            end else if (le_s && dest_hit[g]) begin
               latch_q[g] <= payload;
            end
         end
      end
   endgenerate

   // lock select is shared; the latest load of either loop sets it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sel_q <= '0;
      end else if (le_s) begin
         sel_q <= {sr_q[`SEL_HI_POS], sr_q[`SEL_LO_POS]};
      end
   end
   assign sel = synth_pkg::lock_sel_t'(sel_q);

   // fixed reference divider on oscillator edges
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ref_cnt_q  <= '0;
         ref_tick_q <= 1'b0;
      end else begin
         ref_tick_q <= rise[`PIN_REF] && (ref_cnt_q == `REF_DIV_LAST);
         if (rise[`PIN_REF]) begin
            ref_cnt_q <= (ref_cnt_q == `REF_DIV_LAST) ? '0 :
                         ref_cnt_q + `REF_W'(1);
         end
      end
   end

   // transmit loop always runs; receive follows power save
   assign run = {ps_s, 1'b1};

   // per-loop divider and phase detector
   generate
      for (genvar g = 0; g < 2; g++) begin : g_loop
         loop_divider u_div (
            .hclk          (hclk),
            .hresetn       (hresetn),
            .run           (run[g]),
            .in_edge       (rise[`PIN_TXIN + g]),
            .main_ratio    (latch_q[g][`LATCH_W-1:`SWAL_W+1]),
            .swallow_ratio (latch_q[g][`SWAL_W:1]),
            .cmp_tick      (cmp_tick[g])
         );
         phase_compare u_pd (
            .hclk     (hclk),
            .hresetn  (hresetn),
            .run      (run[g]),
            .ref_tick (ref_tick_q),
            .cmp_tick (cmp_tick[g]),
            .invert   (latch_q[g][`LATCH_PHASE]),
            .pump_out (pump_out[g]),
            .pump_oe  (pump_oe[g]),
            .locked   (locked[g])
         );
      end
   endgenerate

   // half-rate square waves so a rate can be watched on the lock pin
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ref_sq_q <= 1'b0;
         cmp_sq_q <= '0;
      end else begin
         ref_sq_q <= ref_sq_q ^ ref_tick_q;
         cmp_sq_q <= cmp_sq_q ^ cmp_tick;
      end
   end

   // lock output source; stand-by forces it low
   always_comb begin
      lock_lvl_d = 1'b0;
      case (sel)
         synth_pkg::SEL_LOCK:     lock_lvl_d = locked[0] && locked[1];
         synth_pkg::SEL_RX_RATE:  lock_lvl_d = cmp_sq_q[1] ^ ~latch_q[1][`LATCH_PHASE];
         synth_pkg::SEL_TX_RATE:  lock_lvl_d = cmp_sq_q[0] ^ ~latch_q[0][`LATCH_PHASE];
         synth_pkg::SEL_REF_RATE: lock_lvl_d = ref_sq_q;
         default:                 lock_lvl_d = 1'b0;
      endcase
      if (!ps_s) begin
         lock_lvl_d = 1'b0;
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lock_lvl_q <= 1'b0;
      end else begin
         lock_lvl_q <= lock_lvl_d;
      end
   end

   // open drain: pull low or release
   assign lock_status_out = 1'b0;
   assign lock_status_oe  = ~lock_lvl_q;

   // each pump floats when its own detector is idle; receive pump also in stand-by
   assign tx_pump_out = pump_out[0];
   assign tx_pump_oe  = pump_oe[0];
   assign rx_pump_out = pump_out[1];
   assign rx_pump_oe  = pump_oe[1] && ps_s;

   // switch conducts only while loading its own loop
   assign tx_switch_out = pump_out[0];
   assign tx_switch_oe  = le_s && sr_q[`DEST_POS] && pump_oe[0];
   assign rx_switch_out = pump_out[1];
   assign rx_switch_oe  = le_s && !sr_q[`DEST_POS] && rx_pump_oe;

   // register read mux
   function automatic logic [31:0] reg_read(input logic [11:0] a);
      if (a == `A_CTRL) begin
         reg_read = {31'h0, shift_en_q};
      end else if (a == `A_TX_LATCH) begin
         reg_read = {13'h0, latch_q[0]};
      end else if (a == `A_RX_LATCH) begin
         reg_read = {13'h0, latch_q[1]};
      end else if (a == `A_STATUS) begin
         reg_read = {26'h0, sel_q, ps_s, lock_lvl_q, locked[1], locked[0]};
      end else begin
         reg_read = 32'h0;
      end
   endfunction

   // zero-wait slave: read data latched at the address phase
   assign bus_acc = hsel && htrans[1] && hready;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= '0;
         hrdata_q  <= '0;
      end else begin
         wr_pend_q <= bus_acc && hwrite;
         if (bus_acc) begin
            wr_addr_q <= haddr[11:0];
         end
         if (bus_acc && !hwrite) begin
            hrdata_q <= reg_read(haddr[11:0]);
         end
      end
   end

   // control write in the data phase; stopping shifts freezes the word
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         shift_en_q <= `CTRL_RST;
      end else if (wr_pend_q && wr_addr_q == `A_CTRL) begin
         shift_en_q <= hwdata[0];
      end
   end
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_q;

   property p_shift;
      @(posedge hclk) disable iff (!hresetn)
      rise[`PIN_SCLK] && shift_en_q |=> sr_q == $past(sr_shifted);
   endproperty
   a_shift: assert property (p_shift)
      else $error("serial bit not shifted in");

   property p_tx_load;
      @(posedge hclk) disable iff (!hresetn)
      le_s && sr_q[`DEST_POS] |=> latch_q[0] == $past(payload);
   endproperty
   a_tx_load: assert property (p_tx_load)
      else $error("transmit latch not loaded");

   property p_rx_hold;
      @(posedge hclk) disable iff (!hresetn)
      le_s && sr_q[`DEST_POS] |=> latch_q[1] == $past(latch_q[1]);
   endproperty
   a_rx_hold: assert property (p_rx_hold)
      else $error("receive latch disturbed by transmit load");

   property p_switch_off;
      @(posedge hclk) disable iff (!hresetn)
      !le_s |-> !tx_switch_oe && !rx_switch_oe;
   endproperty
   a_switch_off: assert property (p_switch_off)
      else $error("switch on without load strobe");

   property p_standby;
      @(posedge hclk) disable iff (!hresetn)
      !ps_s ##1 !ps_s |-> !rx_pump_oe && lock_status_oe && !rx_switch_oe;
   endproperty
   a_standby: assert property (p_standby)
      else $error("receive stand-by not honoured");

   property p_lock_sel;
      @(posedge hclk) disable iff (!hresetn)
      ps_s && sel_q == 2'h0 |=> lock_status_oe == !$past(locked[0] && locked[1]);
   endproperty
   a_lock_sel: assert property (p_lock_sel)
      else $error("lock detector not shown on lock output");

   property p_ref_tick;
      @(posedge hclk) disable iff (!hresetn)
      rise[`PIN_REF] && ref_cnt_q == `REF_DIV_LAST |=> ref_tick_q && ref_cnt_q == '0;
   endproperty
   a_ref_tick: assert property (p_ref_tick)
      else $error("reference divider did not wrap at 1700");

   property p_open_drain;
      @(posedge hclk) disable iff (!hresetn)
      lock_status_oe |-> !lock_status_out;
   endproperty
   a_open_drain: assert property (p_open_drain)
      else $error("lock output driven high");
endmodule

// ===== tb/serial_host.sv
`timescale 1ns/1ps

module serial_host (
   output logic data_pin,
   output logic clock_pin,
   output logic load_pin
);
   // idle: serial clock parked low, no load
   initial begin
      data_pin = 1'b0;
      clock_pin = 1'b0;
      load_pin = 1'b0;
   end

   // only data, clock and load are used, no acknowledge
   // first bit out lands at position 22, destination bit goes last
   // 64 ns link period, 16 ns setup before each rising clock
   task automatic shift_word(input logic [22:0] w);
      #1;
      for (int i = 22; i >= 0; i--) begin
         data_pin <= w[i];
         #16 clock_pin <= 1'b1;
         #32 clock_pin <= 1'b0;
         #16;
      end
      data_pin <= ~w[0];   // hold over: no stale level left behind
      load_pin <= 1'b1;
   endtask

   // clock never moves while load is high
   task automatic drop_load;
      load_pin <= 1'b0;
      #200;
   endtask
endmodule

// ===== tb/tb.sv
`timescale 1ns/1ps

module tb;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic        sdata;
   logic        sclk;
   logic        sload;
   logic        power_save_pin = 1'b1;
   logic [7:0]  osc_cnt = 8'h00;
   logic        tx_pump_out, tx_pump_oe, rx_pump_out, rx_pump_oe;
   logic        tx_switch_out, tx_switch_oe, rx_switch_out, rx_switch_oe;
   logic        lock_status_out, lock_status_oe;
   int          miscompares = 0;
   int          total_checks = 0;

   always #2.5 hclk = ~hclk;
   // slow free-running feedback and reference edges, 3+ cycles apart
   always @(posedge hclk) osc_cnt <= osc_cnt + 8'h01;

   serial_host u_host (.data_pin(sdata), .clock_pin(sclk), .load_pin(sload));

   synth_ctrl u_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .serial_data_pin(sdata), .serial_clock_pin(sclk), .load_strobe(sload),
      .power_save_pin(power_save_pin), .ref_osc_input(osc_cnt[2]),
      .tx_prescaler_input(osc_cnt[3]), .rx_prescaler_input(osc_cnt[4]),
      .tx_pump_out(tx_pump_out), .tx_pump_oe(tx_pump_oe), .rx_pump_out(rx_pump_out),
      .rx_pump_oe(rx_pump_oe), .tx_switch_out(tx_switch_out), .tx_switch_oe(tx_switch_oe),
      .rx_switch_out(rx_switch_out), .rx_switch_oe(rx_switch_oe),
      .lock_status_out(lock_status_out), .lock_status_oe(lock_status_oe));

   task report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // one single word transfer; bounded waits on hready
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 40);
      htrans <= 2'h0;
      hwdata <= d;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 40);
      q = hrdata;
      if (n >= 40) begin
         miscompares++;
         report_and_stop();
      end
   endtask

   // spare bit always sent low
   function automatic logic [22:0] mk(input logic [10:0] m, input logic [6:0] s,
                                      input logic p, input logic [1:0] sel, input logic d);
      return {m, s, p, 1'b0, sel, d};
   endfunction

   // shift, hold load a while, check switch gating, release
   // d is the destination really held: a blocked shift keeps the old word
   task automatic load(input logic [22:0] w, input logic d);
      logic [3:0] own;
      u_host.shift_word(w);
      repeat (12) @(posedge hclk);
      own = d ? {tx_switch_oe, tx_pump_oe, tx_switch_out, tx_pump_out}
              : {rx_switch_oe, rx_pump_oe, rx_switch_out, rx_pump_out};
      check("sw_other", 32'(d ? rx_switch_oe : tx_switch_oe), 32'h0);
      check("sw_pass", 32'(own[3]), 32'(own[2]));
      check("sw_lvl", 32'(own[1]), 32'(own[0]));
      u_host.drop_load();
      check("sw_off", 32'({tx_switch_oe, rx_switch_oe}), 32'h0);
   endtask

   initial begin
      logic [31:0] q;
      logic [22:0] tx;
      logic [22:0] rx;
      int          n;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      ahb(1'b0, 32'h0, 32'h0, q);
      check("ctrl_rst", q, 32'h1);
      ahb(1'b0, 32'h8, 32'h0, q);
      check("rx_rst", q, 32'h1001);
      ahb(1'b0, 32'h10, 32'h0, q);
      check("unmapped", q, 32'h0);
      // swallow 127 stays below main, main at least 16
      tx = mk(11'h5A5, 7'h7F, 1'b0, 2'h2, 1'b1);
      load(tx, 1'b1);
      ahb(1'b0, 32'h4, 32'h0, q);
      check("tx_latch", q, {13'h0, tx[22:4]});
      ahb(1'b0, 32'h8, 32'h0, q);
      check("rx_kept", q, 32'h1001);
      // every select code through receive loads, main from 2047 down
      for (int i = 0; i < 4; i++) begin
         rx = mk(11'h7FF - 11'(i), 7'(i * 40), i[0], 2'(i), 1'b0);
         load(rx, 1'b0);
         ahb(1'b0, 32'h8, 32'h0, q);
         check("rx_latch", q, {13'h0, rx[22:4]});
         ahb(1'b0, 32'h4, 32'h0, q);
         check("tx_kept", q, {13'h0, tx[22:4]});
         ahb(1'b0, 32'hC, 32'h0, q);
         check("sel", 32'(q[5:4]), 32'(i));
         if (i == 0) check("lock_low", 32'(lock_status_oe), 32'h1);
      end
      // shifting blocked: old receive word reloads, transmit untouched
      ahb(1'b1, 32'h0, 32'h0, q);
      ahb(1'b0, 32'h0, 32'h0, q);
      check("ctrl_wr", q, 32'h0);
      // stale receive word (destination low) is what gets loaded
      load(mk(11'h123, 7'h01, 1'b1, 2'h0, 1'b1), 1'b0);
      ahb(1'b0, 32'h4, 32'h0, q);
      check("tx_noshift", q, {13'h0, tx[22:4]});
      ahb(1'b1, 32'h0, 32'h1, q);
      // stand-by of the receive loop
      @(posedge hclk);
      power_save_pin <= 1'b0;
      repeat (8) @(posedge hclk);
      check("rx_pump_z", 32'(rx_pump_oe), 32'h0);
      check("lock_pin", 32'(lock_status_oe), 32'h1);
      check("lock_drv", 32'(lock_status_out), 32'h0);
      ahb(1'b0, 32'hC, 32'h0, q);
      check("psave", 32'(q[3]), 32'h0);
      // first reference tick comes well before the first feedback pulse
      n = 0;
      while (tx_pump_oe !== 1'b1 && n < 30000) begin
         @(posedge hclk);
         n++;
      end
      if (n >= 30000) begin
         miscompares++;
         report_and_stop();
      end
      check("pump_lvl", 32'(tx_pump_out), 32'(tx[4]));
      // reference still ahead: transmit switch must pass the driving pump
      load(tx, 1'b1);
      report_and_stop();
   end
endmodule
